// ---- hw/lsirq_pkg.sv ----
package lsirq_pkg;
  // number of request levels per controller
  localparam int NUM_LEVELS = 8;
  // level on the first controller that the cascade request occupies
  localparam int CASCADE_LEVEL = 2;
  // level on the second controller used as the replacement request input
  localparam int REPLACE_LEVEL = 1;
  // vector bases: first controller 0x08, second controller 0x70
  localparam logic [7:0] MASTER_VEC_BASE = 8'h08;
  localparam logic [7:0] SLAVE_VEC_BASE = 8'h70;
  // replacement input vector and legacy shared-level vector
  localparam logic [7:0] REPLACE_VECTOR = 8'h71;
  localparam logic [7:0] LEGACY_VECTOR = 8'h0A;
  // handler settle delays in cycles, before and after the end command
  localparam int SETTLE_CYCLES = 4;
  localparam int COUNT_W = 4;
  // controller select encoding on the command path
  localparam logic CTRL_MASTER = 1'b0;
  localparam logic CTRL_SLAVE = 1'b1;
endpackage

// ---- hw/lsirq_if.sv ----
`timescale 1ns/1ps
interface lsirq_if;
  // processor interrupt line, level
  logic cpu_int;
  // acknowledge strobe and returned vector
  logic int_ack;
  logic [7:0] int_vector;
  logic vector_valid;
  // end-of-interrupt command: strobe, target controller, level
  logic end_of_interrupt_command;
  logic end_ctrl;
  logic [2:0] end_level;
  // attempt to program a trigger mode: 1 means edge requested
  logic mode_write;
  logic mode_edge;
  // latch read and explicit clear strobes, and latch value
  logic latch_read;
  logic latch_clear;
  logic latch_value;
  // in-service visibility for the handler
  logic [7:0] master_in_service;
  logic [7:0] slave_in_service;
  logic edge_mode_seen;

  modport dev (
    output cpu_int, int_vector, vector_valid, latch_value,
    output master_in_service, slave_in_service, edge_mode_seen,
    input int_ack, end_of_interrupt_command, end_ctrl, end_level,
    input mode_write, mode_edge, latch_read, latch_clear
  );
  modport host (
    input cpu_int, int_vector, vector_valid, latch_value,
    input master_in_service, slave_in_service, edge_mode_seen,
    output int_ack, end_of_interrupt_command, end_ctrl, end_level,
    output mode_write, mode_edge, latch_read, latch_clear
  );
endinterface

// ---- hw/lsirq_device.sv ----
`timescale 1ns/1ps
module lsirq_device #(
  parameter int LEVELS = lsirq_pkg::NUM_LEVELS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // device request pins, outside the clock domain
  input wire logic [7:0] master_req_pin,
  input wire logic [7:0] slave_req_pin,
  input wire logic legacy_cascade_request,
  // processor side
  lsirq_if.dev bus
);
  // the encoders and vector sums only serve eight levels
  if (LEVELS != 8) begin : g_bad_levels
    $error("lsirq_device supports eight levels only");
  end

  // synchroniser stages, per request pin
  logic [7:0] m_sync1_reg;
  logic [7:0] m_sync2_reg;
  logic [7:0] s_sync1_reg;
  logic [7:0] s_sync2_reg;
  logic casc_sync1_reg;
  logic casc_sync2_reg;
  // in-service bits and their per-level set and clear terms
  logic [7:0] m_isr_reg;
  logic [7:0] s_isr_reg;
  logic [7:0] m_isr_set;
  logic [7:0] m_isr_clr;
  logic [7:0] s_isr_set;
  logic [7:0] s_isr_clr;
  // level requests, pending levels and chosen level per controller
  logic [7:0] m_req;
  logic [7:0] s_req;
  logic [7:0] m_pend;
  logic [7:0] s_pend;
  logic [2:0] m_lvl;
  logic [2:0] s_lvl;
  logic m_any;
  logic s_any;
  // acknowledge that found a level, and whether the slave owns it
  logic ack_hit;
  logic ack_slave;
  // output registers
  logic cpu_int_reg;
  logic vec_valid_reg;
  logic latch_reg;
  logic edge_seen_reg;
  logic [7:0] vector_reg;

  // two-flop synchronisers, one pair per request bit
  // costs two cycles of latency, but pins may change at any time
  for (genvar i = 0; i < 8; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        m_sync1_reg[i] <= 1'b0;
        m_sync2_reg[i] <= 1'b0;
        s_sync1_reg[i] <= 1'b0;
        s_sync2_reg[i] <= 1'b0;
      end else begin
        m_sync1_reg[i] <= master_req_pin[i];
        m_sync2_reg[i] <= m_sync1_reg[i];
        s_sync1_reg[i] <= slave_req_pin[i];
        s_sync2_reg[i] <= s_sync1_reg[i];
      end
    end
  end

  // cascade line synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      casc_sync1_reg <= 1'b0;
      casc_sync2_reg <= 1'b0;
    end else begin
      casc_sync1_reg <= legacy_cascade_request;
      casc_sync2_reg <= casc_sync1_reg;
    end
  end

  // level requests; slave replacement input also takes the cascade line
  always_comb begin
    m_req = m_sync2_reg;
    s_req = s_sync2_reg;
    s_req[lsirq_pkg::REPLACE_LEVEL] = s_sync2_reg[lsirq_pkg::REPLACE_LEVEL]
      | casc_sync2_reg;
    // slave output enters the master on the cascade level
    m_req[lsirq_pkg::CASCADE_LEVEL] = |(s_req & ~s_isr_reg);
    m_pend = m_req & ~m_isr_reg; // level still high after end re-asks
    s_pend = s_req & ~s_isr_reg;
  end

  // fixed priority, level 0 highest
  // scanned downwards so the lowest pending level is the one kept
  always_comb begin
    m_lvl = 3'h0;
    m_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (m_pend[i]) begin
        m_lvl = i[2:0];
        m_any = 1'b1;
      end
    end
    s_lvl = 3'h0;
    s_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (s_pend[i]) begin
        s_lvl = i[2:0];
        s_any = 1'b1;
      end
    end
  end

  // processor line is high while an unserviced level is requesting
  // low the cycle after an acknowledge so one request is not taken twice
  always_ff @(posedge sys_clk) begin
    if (!rst_n) cpu_int_reg <= 1'b0;
    else cpu_int_reg <= m_any && !bus.int_ack;
  end

  // acknowledge terms shared by the in-service logic
  assign ack_hit = bus.int_ack && m_any;
  assign ack_slave = m_lvl == 3'(lsirq_pkg::CASCADE_LEVEL) && s_any;

  // per-level set strobes from acknowledge, clear strobes from end
  always_comb begin
    m_isr_set = 8'h00;
    s_isr_set = 8'h00;
    m_isr_clr = 8'h00;
    s_isr_clr = 8'h00;
    if (ack_hit) begin
      m_isr_set[m_lvl] = 1'b1;
      if (ack_slave)
        s_isr_set[s_lvl] = 1'b1;
    end
    if (bus.end_of_interrupt_command) begin
      if (bus.end_ctrl == lsirq_pkg::CTRL_MASTER)
        m_isr_clr[bus.end_level] = 1'b1;
      else
        s_isr_clr[bus.end_level] = 1'b1;
    end
  end

  // in-service bits; a set beside a clear wins so no service is lost
  for (genvar i = 0; i < 8; i++) begin : g_isr
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        m_isr_reg[i] <= 1'b0;
        s_isr_reg[i] <= 1'b0;
      end else begin
        if (m_isr_set[i]) m_isr_reg[i] <= 1'b1;
        else if (m_isr_clr[i]) m_isr_reg[i] <= 1'b0;
        if (s_isr_set[i]) s_isr_reg[i] <= 1'b1;
        else if (s_isr_clr[i]) s_isr_reg[i] <= 1'b0;
      end
    end
  end

  // vector returned one cycle after acknowledge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vector_reg <= 8'h00;
      vec_valid_reg <= 1'b0;
    end else begin
      vec_valid_reg <= bus.int_ack && m_any;
      if (bus.int_ack && m_any) begin
        if (m_lvl == 3'(lsirq_pkg::CASCADE_LEVEL) && s_any)
          vector_reg <= lsirq_pkg::SLAVE_VEC_BASE + {5'h00, s_lvl};
        else
          vector_reg <= lsirq_pkg::MASTER_VEC_BASE + {5'h00, m_lvl};
      end
    end
  end

  // in-progress latch: set by acknowledge, cleared by read or clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) latch_reg <= 1'b0;
    else if (bus.int_ack && m_any) latch_reg <= 1'b1; // set wins
    else if (bus.latch_read || bus.latch_clear) latch_reg <= 1'b0;
  end

  // edge-mode attempts are noted but never change the trigger mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) edge_seen_reg <= 1'b0;
    else if (bus.mode_write && bus.mode_edge) edge_seen_reg <= 1'b1;
  end

  assign bus.cpu_int = cpu_int_reg;
  assign bus.int_vector = vector_reg;
  assign bus.vector_valid = vec_valid_reg;
  assign bus.latch_value = latch_reg;
  assign bus.master_in_service = m_isr_reg;
  assign bus.slave_in_service = s_isr_reg;
  assign bus.edge_mode_seen = edge_seen_reg;
endmodule

// ---- hw/lsirq_handler.sv ----
`timescale 1ns/1ps
module lsirq_handler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // device source clear, to the requesting device
  output logic source_clear,
  // processor interrupt enable flag and last vector served
  output logic processor_interrupt_enable,
  output logic [7:0] served_vector,
  // controller side
  lsirq_if.host bus
);
  typedef enum logic [2:0] {
    IDLE = 3'b000, ACK = 3'b001, WAITV = 3'b010, CLEAR = 3'b011,
    DLY1 = 3'b100, SEND_END = 3'b101, DLY2 = 3'b110, END_CASC = 3'b111
  } lsirq_st_type;

  lsirq_st_type st_reg;
  logic [lsirq_pkg::COUNT_W-1:0] cnt_reg;
  logic [7:0] vec_reg;
  logic chain_reg;
  logic ack_reg, end_reg, end_ctrl_reg, clr_reg, rd_reg, ie_reg;
  logic [2:0] end_lvl_reg;

  // handler sequence per interrupt
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= IDLE;
      cnt_reg <= '0;
      vec_reg <= 8'h00;
      chain_reg <= 1'b0;
      ack_reg <= 1'b0;
      end_reg <= 1'b0;
      end_ctrl_reg <= 1'b0;
      end_lvl_reg <= 3'h0;
      clr_reg <= 1'b0;
      rd_reg <= 1'b0;
      ie_reg <= 1'b1;
    end else begin
      ack_reg <= 1'b0;
      end_reg <= 1'b0;
      clr_reg <= 1'b0;
      rd_reg <= 1'b0;
      unique case (st_reg)
        IDLE: begin
          if (bus.cpu_int && ie_reg) begin
            ie_reg <= 1'b0;
            ack_reg <= 1'b1;
            st_reg <= ACK;
          end
        end
        ACK: st_reg <= WAITV;
        WAITV: begin
          if (bus.vector_valid) begin
            rd_reg <= 1'b1;
            if (bus.int_vector == lsirq_pkg::REPLACE_VECTOR) begin
              // slave first, then legacy shared handler
              end_reg <= 1'b1;
              end_ctrl_reg <= lsirq_pkg::CTRL_SLAVE;
              end_lvl_reg <= 3'(lsirq_pkg::REPLACE_LEVEL);
              chain_reg <= 1'b1;
              vec_reg <= lsirq_pkg::LEGACY_VECTOR;
            end else begin
              vec_reg <= bus.int_vector;
            end
            st_reg <= CLEAR;
          end else begin
            // acknowledge met nothing pending: give up instead of hanging
            ie_reg <= 1'b1;
            st_reg <= IDLE;
          end
        end
        CLEAR: begin
          clr_reg <= 1'b1; // drop source before end
          cnt_reg <= '0;
          st_reg <= DLY1;
        end
        DLY1: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == lsirq_pkg::COUNT_W'(lsirq_pkg::SETTLE_CYCLES - 1))
            st_reg <= SEND_END;
        end
        SEND_END: begin
          end_reg <= 1'b1; // sent regardless of request state
          if (chain_reg || vec_reg < lsirq_pkg::SLAVE_VEC_BASE) begin
            end_ctrl_reg <= lsirq_pkg::CTRL_MASTER;
            end_lvl_reg <= chain_reg ? 3'(lsirq_pkg::CASCADE_LEVEL)
              : vec_reg[2:0];
            st_reg <= DLY2;
          end else begin
            // slave level first, its cascade level on the master next
            end_ctrl_reg <= lsirq_pkg::CTRL_SLAVE;
            end_lvl_reg <= vec_reg[2:0];
            st_reg <= END_CASC;
          end
          chain_reg <= 1'b0;
          cnt_reg <= '0;
        end
        END_CASC: begin
          end_reg <= 1'b1;
          end_ctrl_reg <= lsirq_pkg::CTRL_MASTER;
          end_lvl_reg <= 3'(lsirq_pkg::CASCADE_LEVEL);
          st_reg <= DLY2;
        end
        DLY2: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg ==
              lsirq_pkg::COUNT_W'(lsirq_pkg::SETTLE_CYCLES - 1)) begin
            ie_reg <= 1'b1;
            st_reg <= IDLE;
          end
        end
      endcase
    end
  end

  assign bus.int_ack = ack_reg;
  assign bus.end_of_interrupt_command = end_reg;
  assign bus.end_ctrl = end_ctrl_reg;
  assign bus.end_level = end_lvl_reg;
  assign bus.mode_write = 1'b0;
  assign bus.mode_edge = 1'b0;
  assign bus.latch_read = rd_reg;
  assign bus.latch_clear = 1'b0;
  assign source_clear = clr_reg;
  assign processor_interrupt_enable = ie_reg;
  assign served_vector = vec_reg;
endmodule

// ---- dv/lsirq_properties.sv ----
`timescale 1ns/1ps
module lsirq_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // signals between controller and handler
  input wire logic cpu_int,
  input wire logic int_ack,
  input wire logic [7:0] int_vector,
  input wire logic vector_valid,
  input wire logic end_of_interrupt_command,
  input wire logic end_ctrl,
  input wire logic [2:0] end_level,
  input wire logic [7:0] master_in_service,
  input wire logic [7:0] slave_in_service
);
  logic end_m;
  logic end_s;
  // end command per controller; an ack beside it wins the bit
  assign end_m = end_of_interrupt_command &&
    end_ctrl == lsirq_pkg::CTRL_MASTER;
  assign end_s = end_of_interrupt_command &&
    end_ctrl == lsirq_pkg::CTRL_SLAVE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // vectors out of each controller's range
  sequence s_vec_m;
    vector_valid && int_vector[7:3] == lsirq_pkg::MASTER_VEC_BASE[7:3];
  endsequence
  sequence s_vec_s;
    vector_valid && int_vector[7:3] == lsirq_pkg::SLAVE_VEC_BASE[7:3];
  endsequence
  a_ack_vector: assert property (cpu_int && int_ack |=> vector_valid)
    else $error("ack gave no vector");
  a_vector_pulse: assert property (vector_valid |=> !vector_valid)
    else $error("vector valid held too long");
  a_master_set: assert property (
    s_vec_m |-> master_in_service[int_vector[2:0]])
    else $error("master in-service not set");
  a_slave_set: assert property (
    s_vec_s |-> slave_in_service[int_vector[2:0]])
    else $error("slave in-service not set");
  a_master_end: assert property (
    end_m && !int_ack |=> !master_in_service[$past(end_level)])
    else $error("master in-service not cleared");
  a_slave_end: assert property (
    end_s && !int_ack |=> !slave_in_service[$past(end_level)])
    else $error("slave in-service not cleared");
  a_master_hold: assert property (
    |($past(master_in_service) & ~master_in_service) |-> $past(end_m))
    else $error("master in-service dropped early");
  a_slave_hold: assert property (
    |($past(slave_in_service) & ~slave_in_service) |-> $past(end_s))
    else $error("slave in-service dropped early");
endmodule

// ---- dv/lsirq_tb.sv ----
`timescale 1ns/1ps
module lsirq_tb;
  logic sys_clk;
  logic rst_n;
  logic [7:0] m_req;
  logic [7:0] s_req;
  logic leg_req;
  logic [7:0] m2_req;
  logic src_clr;
  logic int_en;
  logic [7:0] served;
  logic [7:0] expq[$];
  int fails;
  int checked;
  int cycles;
  int n;
  int lvl;
  int linger;
  lsirq_if bus_a();
  lsirq_if bus_b();
  // controller and handler joined as in the system
  lsirq_device i_lsirq_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .master_req_pin(m_req), .slave_req_pin(s_req),
    .legacy_cascade_request(leg_req), .bus(bus_a.dev));
  lsirq_handler i_lsirq_handler (.sys_clk(sys_clk), .rst_n(rst_n),
    .source_clear(src_clr), .processor_interrupt_enable(int_en),
    .served_vector(served), .bus(bus_a.host));
  // spare controller; the bench plays a careless host on it
  lsirq_device i_lsirq_device_b (.sys_clk(sys_clk), .rst_n(rst_n),
    .master_req_pin(m2_req), .slave_req_pin(8'h00),
    .legacy_cascade_request(1'b0), .bus(bus_b.dev));
  lsirq_properties i_lsirq_properties (.sys_clk(sys_clk),
    .rst_n(rst_n), .cpu_int(bus_a.cpu_int), .int_ack(bus_a.int_ack),
    .int_vector(bus_a.int_vector), .vector_valid(bus_a.vector_valid),
    .end_of_interrupt_command(bus_a.end_of_interrupt_command),
    .end_ctrl(bus_a.end_ctrl), .end_level(bus_a.end_level),
    .master_in_service(bus_a.master_in_service),
    .slave_in_service(bus_a.slave_in_service));

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // raise lines, wait until served and every master in-service bit is gone
  task automatic serve(input logic [16:0] pins, input logic [7:0] v,
      input int reps);
    repeat (reps) expq.push_back(v);
    linger = reps - 1;
    {leg_req, s_req, m_req} <= pins;
    n = 0;
    @(negedge sys_clk);
    while (n < 400 && (expq.size() != 0 || {leg_req, s_req, m_req} != 0 ||
        int_en !== 1'b1 || bus_a.master_in_service !== 8'h00)) begin
      @(negedge sys_clk);
      n++;
    end
    chk(bus_a.master_in_service | bus_a.slave_in_service, 8'h00);
    chk({7'h00, bus_a.latch_value}, 8'h00);
    chk(8'(expq.size()), 8'h00);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // requesting device drops its line on a clear, unless told to linger
  always @(negedge sys_clk) begin
    if (src_clr === 1'b1) begin
      if (linger > 0)
        linger--;
      else
        {leg_req, s_req, m_req} <= '0;
    end
    if (bus_a.vector_valid === 1'b1)
      chk(bus_a.int_vector, expq.size() > 0 ? expq.pop_front() : 8'hXX);
  end

  initial begin
    fails = 0;
    checked = 0;
    cycles = 0;
    linger = 0;
    rst_n = 1'b0;
    {leg_req, s_req, m_req, m2_req} = '0;
    {bus_b.int_ack, bus_b.end_of_interrupt_command, bus_b.end_ctrl,
      bus_b.end_level, bus_b.mode_write, bus_b.mode_edge,
      bus_b.latch_read, bus_b.latch_clear} = '0;
    lvl = $urandom(52889);
    repeat (10) @(negedge sys_clk);
    rst_n <= 1'b1;
    // random single levels; master level two is the cascade
    repeat (12) begin
      lvl = $urandom % 16;
      if (lvl == lsirq_pkg::CASCADE_LEVEL)
        lvl = 3;
      serve(17'h00001 << lvl, (lvl < 8 ? lsirq_pkg::MASTER_VEC_BASE :
        lsirq_pkg::SLAVE_VEC_BASE - 8'h08) + 8'(lvl), 1);
    end
    serve(17'h10000, lsirq_pkg::REPLACE_VECTOR, 1);
    chk(served, lsirq_pkg::LEGACY_VECTOR);
    // line left up past the end command interrupts once more
    serve(17'h00010, lsirq_pkg::MASTER_VEC_BASE + 8'h04, 2);
    // spare controller: edge mode asked for, line kept high throughout
    {bus_b.mode_write, bus_b.mode_edge} <= 2'b11;
    @(negedge sys_clk);
    {bus_b.mode_write, bus_b.mode_edge} <= 2'b00;
    m2_req <= 8'h20;
    repeat (2) begin
      n = 0;
      while (n < 20 && bus_b.cpu_int !== 1'b1) begin
        @(negedge sys_clk);
        n++;
      end
      chk({7'h00, bus_b.cpu_int}, 8'h01);
      bus_b.int_ack <= 1'b1;
      @(negedge sys_clk);
      bus_b.int_ack <= 1'b0;
      chk(bus_b.int_vector, lsirq_pkg::MASTER_VEC_BASE + 8'h05);
      chk({7'h00, bus_b.latch_value}, 8'h01);
      bus_b.latch_clear <= 1'b1;
      @(negedge sys_clk);
      bus_b.latch_clear <= 1'b0;
      bus_b.end_of_interrupt_command <= 1'b1;
      bus_b.end_level <= 3'h5;
      @(negedge sys_clk);
      bus_b.end_of_interrupt_command <= 1'b0;
      chk({7'h00, bus_b.latch_value}, 8'h00);
    end
    chk({7'h00, bus_b.edge_mode_seen}, 8'h01);
    end_of_test();
  end
endmodule
